// File: core/adc_out_ctrl.sv
// output side of the flash converter: phase control, result pipeline, FIFO,
// output register and tri-state enables
// assumes comparator latches present a thermometer word, control pins asynchronous
module adc_out_ctrl (
    input  wire logic                             REF_CLK_I,
    input  wire logic                             ARST_N_I,
    input  wire logic                             CONV_CLK_I,
    input  wire logic                             SAMPLE_PHASE_SEL_I,
    input  wire logic                             CODE_BITS_DISABLE_I,
    input  wire logic                             ALL_OUTPUTS_ENABLE_N_I,
    input  wire logic [adc_out_pkg::THERMO_W-1:0] COMPARATOR_I,
    input  wire logic                             CAPTURE_READY_I,
    output      logic                             SAMPLE_PHASE_O,
    output      logic                             BALANCE_PHASE_O,
    output      logic                             RESULT_ACCEPT_O,
    output      logic                             RESULT_DROPPED_O,
    output      logic                             CODE_VALID_O,
    output      logic [adc_out_pkg::CODE_W-1:0]   CONVERSION_CODE_O,
    output      logic                             CONVERSION_CODE_OE_O,
    output      logic                             OVER_RANGE_FLAG_O,
    output      logic                             OVER_RANGE_FLAG_OE_O
);
    localparam int S = adc_out_pkg::SYNC_STAGES;

    // ************************************************************
    // helpers
    // ************************************************************
    // thermometer to binary: count of tripped comparators, 256 = over-range
    function automatic adc_out_pkg::conv_word_s therm_decode(
        input logic [adc_out_pkg::THERMO_W-1:0] t);
        logic [8:0] n;
        n = 9'h000;
        for (int i = 0; i < adc_out_pkg::THERMO_W; i++) begin
            n = n + 9'(t[i]);
        end
        therm_decode = {n[8], n[7:0]};
    endfunction : therm_decode

    // a pin level counts once the last two stages agree
    function automatic logic sync_filter(input logic [S-1:0] sh, input logic prev);
        sync_filter = (sh[S-1] == sh[S-2]) ? sh[S-1] : prev;
    endfunction : sync_filter

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [S-1:0] clk_sh_q, ph_sh_q, dis_sh_q, en_sh_q;
    logic         clk_f_q, ph_f_q, dis_f_q, en_n_f_q;
    logic         clk_f_d, ph_f_d, dis_f_d, en_n_f_d;

    // filtered levels
    always_comb begin
        clk_f_d  = sync_filter(clk_sh_q, clk_f_q);
        ph_f_d   = sync_filter(ph_sh_q, ph_f_q);
        dis_f_d  = sync_filter(dis_sh_q, dis_f_q);
        en_n_f_d = sync_filter(en_sh_q, en_n_f_q);
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            clk_sh_q <= {S{adc_out_pkg::CLKIN_RST}};
            ph_sh_q  <= {S{adc_out_pkg::PHSEL_RST}};
            dis_sh_q <= {S{adc_out_pkg::DIS_RST}};
            en_sh_q  <= {S{adc_out_pkg::EN_N_RST}};
            clk_f_q  <= adc_out_pkg::CLKIN_RST;
            ph_f_q   <= adc_out_pkg::PHSEL_RST;
            dis_f_q  <= adc_out_pkg::DIS_RST;
            en_n_f_q <= adc_out_pkg::EN_N_RST;
        end else begin
            clk_sh_q <= {clk_sh_q[S-2:0], CONV_CLK_I};
            ph_sh_q  <= {ph_sh_q[S-2:0], SAMPLE_PHASE_SEL_I};
            dis_sh_q <= {dis_sh_q[S-2:0], CODE_BITS_DISABLE_I};
            en_sh_q  <= {en_sh_q[S-2:0], ALL_OUTPUTS_ENABLE_N_I};
            clk_f_q  <= clk_f_d;
            ph_f_q   <= ph_f_d;
            dis_f_q  <= dis_f_d;
            en_n_f_q <= en_n_f_d;
        end
    end

    // ************************************************************
    // comparator phase
    // ************************************************************
    adc_out_pkg::phase_e phase_q, phase_d;
    logic                eff_clk;
    logic                end_sample, end_balance;

    // phase select complements the incoming clock
    always_comb begin
        eff_clk     = clk_f_q ^ ph_f_q;
        phase_d     = eff_clk ? adc_out_pkg::PH_BALANCE
                              : adc_out_pkg::PH_SAMPLE;
        end_sample  = (phase_q == adc_out_pkg::PH_SAMPLE) && (phase_d == adc_out_pkg::PH_BALANCE);
        end_balance = (phase_q == adc_out_pkg::PH_BALANCE) && (phase_d == adc_out_pkg::PH_SAMPLE);
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            phase_q <= adc_out_pkg::PH_BALANCE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ************************************************************
    // result pipeline: latch, second latch, decode into FIFO
    // ************************************************************
    logic [adc_out_pkg::THERMO_W-1:0] lat1_q, lat1_d, lat2_q, lat2_d;
    logic                             v1_q, v1_d, v2_q, v2_d;
    logic                             drop_q, drop_d;
    logic                             push, fifo_ready;
    adc_out_pkg::conv_word_s          push_word;

    // capture at sample end, pass on at balance end, load at next sample end
    always_comb begin
        lat1_d    = end_sample ? COMPARATOR_I : lat1_q;
        v1_d      = end_sample ? 1'b1 : (end_balance ? 1'b0 : v1_q);
        lat2_d    = end_balance ? lat1_q : lat2_q;
        v2_d      = end_balance ? v1_q : (end_sample ? 1'b0 : v2_q);
        push      = end_sample && v2_q;
        push_word = therm_decode(lat2_q);
        drop_d    = drop_q || (push && !fifo_ready);
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lat1_q <= '0;
            lat2_q <= '0;
            v1_q   <= 1'b0;
            v2_q   <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            lat1_q <= lat1_d;
            lat2_q <= lat2_d;
            v1_q   <= v1_d;
            v2_q   <= v2_d;
            drop_q <= drop_d;
        end
    end

    // ************************************************************
    // buffer between decoder and output register
    // ************************************************************
    logic                    fifo_valid, pop;
    logic [8:0]              fifo_data;
    adc_out_pkg::conv_word_s out_q, out_d;
    logic                    cv_q, cv_d;

    word_fifo #(
        .WIDTH (9),
        .DEPTH (adc_out_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (REF_CLK_I),
        .arst_n_i    (ARST_N_I),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_data)
    );

    // ************************************************************
    // output register and tri-state enables
    // ************************************************************
    logic code_oe_q, code_oe_d, of_oe_q, of_oe_d;

    always_comb begin
        pop       = fifo_valid && (CAPTURE_READY_I || !cv_q);
        out_d     = pop ? adc_out_pkg::conv_word_s'(fifo_data) : out_q;
        cv_d      = pop ? 1'b1 : (CAPTURE_READY_I ? 1'b0 : cv_q);
        of_oe_d   = en_n_f_q;
        code_oe_d = en_n_f_q && !dis_f_q;
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            out_q     <= adc_out_pkg::WORD_RST;
            cv_q      <= 1'b0;
            code_oe_q <= 1'b0;
            of_oe_q   <= 1'b0;
        end else begin
            out_q     <= out_d;
            cv_q      <= cv_d;
            code_oe_q <= code_oe_d;
            of_oe_q   <= of_oe_d;
        end
    end

    // port drive
    always_comb begin
        SAMPLE_PHASE_O       = (phase_q == adc_out_pkg::PH_SAMPLE);
        BALANCE_PHASE_O      = (phase_q == adc_out_pkg::PH_BALANCE);
        RESULT_ACCEPT_O      = fifo_ready;
        RESULT_DROPPED_O     = drop_q;
        CODE_VALID_O         = cv_q;
        CONVERSION_CODE_O    = out_q.code;
        OVER_RANGE_FLAG_O    = out_q.over_range;
        CONVERSION_CODE_OE_O = code_oe_q;
        OVER_RANGE_FLAG_OE_O = of_oe_q;
    end

    // ************************************************************
    // checks
    // ************************************************************
    all_float_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        !en_n_f_q |=> !CONVERSION_CODE_OE_O && !OVER_RANGE_FLAG_OE_O)
        else $error("outputs driven while disabled");
    code_float_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (en_n_f_q && dis_f_q) |=> !CONVERSION_CODE_OE_O && OVER_RANGE_FLAG_OE_O)
        else $error("code not floated alone");
    all_drive_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (en_n_f_q && !dis_f_q) |=> CONVERSION_CODE_OE_O && OVER_RANGE_FLAG_OE_O)
        else $error("outputs not driven");
    sample_low_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (!ph_f_q && !clk_f_q) |=> SAMPLE_PHASE_O && !BALANCE_PHASE_O)
        else $error("no sample on low clock");
    balance_high_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (!ph_f_q && clk_f_q) |=> BALANCE_PHASE_O && !SAMPLE_PHASE_O)
        else $error("no balance on high clock");
    phase_invert_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (ph_f_q && clk_f_q) |=> SAMPLE_PHASE_O)
        else $error("phase select not inverting");
    load_edge_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        push |-> end_sample && $past(v2_q) && v2_q)
        else $error("result loaded off its edge");
    code_map_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        pop |=> {OVER_RANGE_FLAG_O, CONVERSION_CODE_O} == $past(fifo_data) && CODE_VALID_O)
        else $error("output word mismatch");

endmodule : adc_out_ctrl

// File: core/adc_out_pkg.sv
// constants and carrier types shared by the converter output path
// assumes a single 200 MHz clock and an asynchronous active-low reset
// Behaviour
// - A low all_outputs_enable_n floats all eight code outputs and the over-range output.
// - With all_outputs_enable_n high and code_bits_disable high the code floats but over-range is driven.
// - With code_bits_disable low and all_outputs_enable_n high all nine outputs are driven.
// - With the phase select low the input is sampled while the conversion clock is low.
// - With the phase select low the comparators auto-balance while the conversion clock is high.
// - With the phase select high the conversion clock is taken inverted.
// - A result is loaded on the next same-polarity edge after the edge that ends its sample.
package adc_out_pkg;

    // ************************************************************
    // widths and depths
    // ************************************************************
    localparam int CODE_W      = 8;
    localparam int THERMO_W    = 256;
    localparam int FIFO_DEPTH  = 32;
    localparam int SYNC_STAGES = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic       EN_N_RST   = 1'b0;   // outputs floated until enabled
    localparam logic       DIS_RST    = 1'b1;
    localparam logic       PHSEL_RST  = 1'b0;
    localparam logic       CLKIN_RST  = 1'b0;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic              over_range;
        logic [CODE_W-1:0] code;
    } conv_word_s;

    localparam conv_word_s WORD_RST = '{over_range: 1'b0, code: 8'h00};

    // comparator phase, one-hot
    typedef enum logic [1:0] {
        PH_BALANCE = 2'b01,
        PH_SAMPLE  = 2'b10
    } phase_e;

endpackage : adc_out_pkg

// File: core/word_fifo.sv
// synchronous word FIFO with valid/ready on both sides
// assumes one clock; width and depth shape the storage
module word_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             in_valid_i,
    output      logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output      logic             out_valid_o,
    input  wire logic             out_ready_i,
    output      logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // ************************************************************
    // pointer and count update
    // ************************************************************
    always_comb begin
        in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
        out_valid_o = (cnt_q != '0);
        out_data_o  = mem_q[rd_q];
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wr_d        = push ? wr_q + 1'b1 : wr_q;
        rd_d        = pop ? rd_q + 1'b1 : rd_q;
        cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    count_bound_a : assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
    push_count_a : assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (push && !pop) |=> cnt_q == $past(cnt_q) + 1'b1) else $error("push lost");

endmodule : word_fifo

// File: test/adc_out_ctrl_test.sv
// self-checking bench for the converter output control block
// assumes capture_model on the far side and a 200 MHz reference clock
`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module adc_out_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // stimulus, design and far side
    // ************************************************************
    logic         ref_clk = 1'b0;
    logic         arst_n, conv_clk, phase_sel, code_dis, en_n, stall;
    logic [255:0] comparator;
    logic         ready, sample_ph, balance_ph, accept, dropped, valid;
    logic         code_oe, over, over_oe;
    logic [7:0]   code;
    int           mismatches = 0;
    int           checked    = 0;

    // reference clock, 5 ns period
    always #2.5 ref_clk = ~ref_clk;

    adc_out_ctrl dut (
        .REF_CLK_I              (ref_clk),
        .ARST_N_I               (arst_n),
        .CONV_CLK_I             (conv_clk),
        .SAMPLE_PHASE_SEL_I     (phase_sel),
        .CODE_BITS_DISABLE_I    (code_dis),
        .ALL_OUTPUTS_ENABLE_N_I (en_n),
        .COMPARATOR_I           (comparator),
        .CAPTURE_READY_I        (ready),
        .SAMPLE_PHASE_O         (sample_ph),
        .BALANCE_PHASE_O        (balance_ph),
        .RESULT_ACCEPT_O        (accept),
        .RESULT_DROPPED_O       (dropped),
        .CODE_VALID_O           (valid),
        .CONVERSION_CODE_O      (code),
        .CONVERSION_CODE_OE_O   (code_oe),
        .OVER_RANGE_FLAG_O      (over),
        .OVER_RANGE_FLAG_OE_O   (over_oe)
    );

    capture_model capture (
        .clk_i     (ref_clk),
        .arst_n_i  (arst_n),
        .valid_i   (valid),
        .code_i    (code),
        .code_oe_i (code_oe),
        .over_i    (over),
        .over_oe_i (over_oe),
        .stall_i   (stall),
        .ready_o   (ready)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // inputs change 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    function automatic logic [255:0] thermo(input int n);
        thermo = (n == 0) ? '0 : ({256{1'b1}} >> (256 - n));
    endfunction : thermo

    function automatic adc_out_pkg::conv_word_s word(input int n);
        word.over_range = (n == 256);
        word.code       = n[7:0];
    endfunction : word

    // one conversion clock period: sample half low, balance half high
    task automatic conv(input int n);
        comparator = thermo(n);
        conv_clk   = 1'b0;
        tick(10);
        conv_clk   = 1'b1;
        tick(10);
    endtask : conv

    // one idle period, then forget whatever arrived so far
    task automatic prime();
        conv(0);
        capture.words.delete();
    endtask : prime

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic check_phases();
        for (int i = 0; i < 4; i++) begin
            {phase_sel, conv_clk} = i[1:0];
            tick(8);
            `CHK(balance_ph, phase_sel ^ conv_clk)
            `CHK(sample_ph, ~(phase_sel ^ conv_clk))
        end
        phase_sel = 1'b0;
    endtask : check_phases

    task automatic check_enables();
        logic [1:0] pins [4];
        pins = '{2'b00, 2'b01, 2'b11, 2'b10};
        for (int i = 0; i < 4; i++) begin
            {en_n, code_dis} = pins[i];
            tick(8);
            `CHK(code_oe, en_n & ~code_dis)
            `CHK(over_oe, en_n)
        end
    endtask : check_enables

    task automatic check_conversions();
        int vals [5];
        vals = '{0, 1, 128, 255, 256};
        prime();
        for (int k = 0; k < 5; k++) begin
            conv(vals[k]);
            `CHK(capture.words.size(), k + 1)
        end
        conv(0);
        for (int k = 0; k < 5; k++) begin
            `CHK(capture.words[k + 1], word(vals[k]))
        end
    endtask : check_conversions

    // far side stalls until the buffer refuses, then drains it
    task automatic check_backpressure();
        prime();
        `CHK(dropped, 1'b0)
        stall = 1'b1;
        for (int j = 0; j < 36; j++) begin
            conv(j * 7);
        end
        `CHK(accept, 1'b0)
        `CHK(dropped, 1'b1)
        stall = 1'b0;
        tick(150);
        `CHK(accept, 1'b1)
        `CHK(capture.words.size(), 33)
        `CHK(capture.words[0], word(0))
        for (int j = 0; j < 32; j++) begin
            `CHK(capture.words[j + 1], word(j * 7))
        end
    endtask : check_backpressure

    // ************************************************************
    // sequence, watchdog and verdict
    // ************************************************************
    task automatic results();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        arst_n     = 1'b0;
        conv_clk   = 1'b0;
        phase_sel  = 1'b0;
        code_dis   = 1'b0;
        en_n       = 1'b1;
        stall      = 1'b0;
        comparator = '0;
        repeat (16) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        tick(8);
        check_phases();
        check_enables();
        check_conversions();
        check_backpressure();
        results();
    end

    // cuts a hang short well beyond the expected 1118 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        results();
    end
endmodule : adc_out_ctrl_test

// File: test/capture_model.sv
// sample capture logic on the far side of the converter output bus
// assumes the bench steers stall; captured words are kept in arrival order
module capture_model (
    input  wire logic                           clk_i,
    input  wire logic                           arst_n_i,
    input  wire logic                           valid_i,
    input  wire logic [adc_out_pkg::CODE_W-1:0] code_i,
    input  wire logic                           code_oe_i,
    input  wire logic                           over_i,
    input  wire logic                           over_oe_i,
    input  wire logic                           stall_i,
    output      logic                           ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // bus view and capture
    // ************************************************************
    adc_out_pkg::conv_word_s words[$];
    adc_out_pkg::conv_word_s bus_w;
    adc_out_pkg::conv_word_s last_q;

    // a floated line has no pull, so it shows the inverse of its last driven level
    always_comb begin
        bus_w.code       = code_oe_i ? code_i : ~last_q.code;
        bus_w.over_range = over_oe_i ? over_i : ~last_q.over_range;
    end

    // ready moves just after the edge; a word is taken when valid meets ready
    initial ready_o = 1'b0;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_q  <= adc_out_pkg::WORD_RST;
            ready_o <= #1 1'b0;
        end else begin
            if (valid_i && ready_o) begin
                words.push_back(bus_w);
            end
            // remember only driven levels so a floated line stays steady
            if (code_oe_i) begin
                last_q.code <= code_i;
            end
            if (over_oe_i) begin
                last_q.over_range <= over_i;
            end
            ready_o <= #1 !stall_i;
        end
    end
endmodule : capture_model
